/* File: rtl/sfs_pkg.sv */
package sfs_pkg;

   // Framing widths: eight bits make a byte on the serial link.
   localparam int unsigned BIT_CNT_W  = 3;
   localparam int unsigned BYTE_CNT_W = 8;
   localparam logic [BIT_CNT_W-1:0]  BIT_LAST   = 3'h7;
   localparam logic [BIT_CNT_W-1:0]  BIT_ZERO   = 3'h0;
   localparam logic [BYTE_CNT_W-1:0] BYTE_ZERO  = 8'h00;
   localparam logic [BYTE_CNT_W-1:0] BYTE_MAX   = 8'hFF;
   localparam logic [7:0]            BYTE_RESET = 8'h00;

   // Power state seen by the rest of the device.
   typedef enum logic [1:0] {
      SFS_PWR_STANDBY,
      SFS_PWR_ACTIVE,
      SFS_PWR_BUSY_HOLD
   } sfs_pwr_t;

endpackage : sfs_pkg

/* File: rtl/sfs_link_if.sv */
`timescale 1ns/10ps
// Signals passed between the link-clock framer and the system-clock controller.
interface sfs_link_if;
   import sfs_pkg::*;
   logic                  byte_tgl;
   logic [7:0]            byte_data;
   logic [BYTE_CNT_W-1:0] byte_idx;
   logic                  tx_bit;

   modport framer (output byte_tgl, output byte_data, output byte_idx, input tx_bit);
   modport ctrl   (input byte_tgl, input byte_data, input byte_idx, output tx_bit);
endinterface : sfs_link_if

/* File: rtl/sfs_sync2.sv */
`timescale 1ns/10ps
module sfs_sync2
   import sfs_pkg::*;
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Level in and out.
   input  wire logic d,
   output logic      q
);

   logic meta_r;

   // Two stages; only the second stage is read outside.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b1;
         q      <= 1'b1;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : sfs_sync2

/* File: rtl/sfs_framer.sv */
`timescale 1ns/10ps
module sfs_framer
   import sfs_pkg::*;
(
   // System reset, for the byte toggle only.
   input  wire logic   rst_n,
   // Link clock and select.
   input  wire logic   sck,
   input  wire logic   cs_n,
   input  wire logic   si,
   // Crossing bundle.
   sfs_link_if.framer  lnk,
   // Serial data out and its enable.
   output logic        so_o,
   output logic        so_oe
);

   logic [BIT_CNT_W-1:0]  bit_cnt_r;
   logic [6:0]            shift_r;
   logic [BYTE_CNT_W-1:0] byte_cnt_r;
   logic [7:0]            byte_r;
   logic                  tgl_r;
   logic                  tx_r;
   logic                  byte_done;

   assign byte_done = (bit_cnt_r == BIT_LAST);

   // Input is sampled on rising sck; select high clears all framing.
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_r  <= BIT_ZERO;
         byte_cnt_r <= BYTE_ZERO;
         shift_r    <= 7'h00;
      end else begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         shift_r   <= {shift_r[5:0], si};
         if (byte_done && byte_cnt_r != BYTE_MAX) begin
            byte_cnt_r <= byte_cnt_r + 8'h01;
         end
      end
   end

   // Each completed byte flips the toggle; reset parks it at the synchroniser's idle level.
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         tgl_r <= 1'b1;
      end else if (!cs_n && byte_done) begin
         tgl_r <= ~tgl_r;
      end
   end

   // Completed bytes are held for the system side; select does not clear them.
   always_ff @(posedge sck) begin
      if (!cs_n && byte_done) begin
         byte_r       <= {shift_r, si};
         lnk.byte_idx <= byte_cnt_r;
      end
   end

   // Output data changes on falling sck.
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         tx_r <= 1'b0;
      end else begin
         tx_r <= lnk.tx_bit;
      end
   end

   assign lnk.byte_tgl  = tgl_r;
   assign lnk.byte_data = byte_r;
   assign so_o  = tx_r;
   assign so_oe = ~cs_n;

endmodule : sfs_framer

/* File: rtl/sfs_select_power.sv */
`timescale 1ns/10ps
module sfs_select_power
   import sfs_pkg::*;
(
   // System clock and reset.
   input  wire logic       mclk,
   input  wire logic       nrst,
   // Serial link pins.
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       si,
   output logic            so_o,
   output logic            so_oe,
   // Internal self-timed operation in progress.
   input  wire logic       op_busy,
   // Outbound serial bit chosen by the command logic.
   input  wire logic       tx_bit,
   // Framing and power status.
   output logic            cmd_start,
   output logic            cmd_end,
   output logic            byte_valid,
   output logic [7:0]      byte_data,
   output logic [7:0]      byte_index,
   output logic            selected,
   output logic            armed,
   output logic            pwr_active,
   output logic            pwr_standby
);

   sfs_link_if lnk ();

   logic                  cs_sync_n;
   logic                  tgl_sync;
   logic                  cs_prev_n_r;
   logic                  tgl_prev_r;
   logic                  armed_r;
   logic                  in_cmd_r;
   logic                  start_r;
   logic                  end_r;
   logic                  bvalid_r;
   logic [7:0]            bdata_r;
   logic [7:0]            bidx_r;
   sfs_pwr_t              pwr_r;
   sfs_pwr_t              pwr_nxt;
   wire                   cs_fall;
   wire                   cs_rise;
   wire                   byte_evt;
   wire                   want_active;
   wire                   want_hold;
   wire                   want_idle;
   wire                   in_cmd_nxt;

   // Link-clock framing logic. It runs only while the host clocks the link,
   // so what it hands over is taken here through a toggle handshake.
   sfs_framer u_framer (
      .rst_n (nrst),
      .sck   (sck),
      .cs_n  (cs_n),
      .si    (si),
      .lnk   (lnk.framer),
      .so_o  (so_o),
      .so_oe (so_oe)
   );

   assign lnk.tx_bit = tx_bit;

   // Select and byte toggle cross into the system clock. Only the toggle
   // crosses for a byte; data and index stand still for eight link clocks,
   // so they are taken once the toggle has settled on this side.
   sfs_sync2 u_cs_sync (
      .clk   (mclk),
      .rst_n (nrst),
      .d     (cs_n),
      .q     (cs_sync_n)
   );

   sfs_sync2 u_tgl_sync (
      .clk   (mclk),
      .rst_n (nrst),
      .d     (lnk.byte_tgl),
      .q     (tgl_sync)
   );

   // Edge decode of the synchronised select and byte toggle.
   assign cs_fall  = cs_prev_n_r & ~cs_sync_n;
   assign cs_rise  = ~cs_prev_n_r & cs_sync_n;
   assign byte_evt = (tgl_sync != tgl_prev_r) & armed_r & in_cmd_r;

   // Power requests: select wins, then a running operation, then idle.
   assign want_active = ~cs_sync_n;
   assign want_hold   = cs_sync_n & op_busy;
   assign want_idle   = cs_sync_n & ~op_busy;

   // Frame flag: set by a select fall, cleared by a select rise.
   assign in_cmd_nxt = cs_fall | (in_cmd_r & ~cs_rise);

   // Edge history registers.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cs_prev_n_r <= 1'b1;
         tgl_prev_r  <= 1'b1; // Matches the toggle's reset level, so no false byte.
      end else begin
         cs_prev_n_r <= cs_sync_n;
         tgl_prev_r  <= tgl_sync;
      end
   end

   // A first falling select arms the device; until then bytes are dropped.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         armed_r <= 1'b0;
      end else if (cs_fall) begin
         armed_r <= 1'b1;
      end
   end

   // Command framing between a fall and a rise of select.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         in_cmd_r <= 1'b0;
         start_r  <= 1'b0;
         end_r    <= 1'b0;
      end else begin
         in_cmd_r <= in_cmd_nxt;
         start_r  <= cs_fall;
         end_r    <= cs_rise & in_cmd_r;
      end
   end

   // Received byte and its position in the command.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bvalid_r <= 1'b0;
         bdata_r  <= BYTE_RESET;
         bidx_r   <= BYTE_RESET;
      end else begin
         bvalid_r <= byte_evt;
         if (byte_evt) begin
            bdata_r <= lnk.byte_data;
            bidx_r  <= lnk.byte_idx;
         end
      end
   end

   // Power state: active while selected, held while an internal op runs.
   // Leaving standby early would waste current, and dropping to standby
   // under a running program or erase would starve it, so both are guarded.
   always_comb begin
      pwr_nxt = pwr_r;
      unique case (pwr_r)
         SFS_PWR_STANDBY: begin
            if (want_active) begin
               pwr_nxt = SFS_PWR_ACTIVE;
            end
         end
         SFS_PWR_ACTIVE: begin
            if (want_hold) begin
               pwr_nxt = SFS_PWR_BUSY_HOLD;
            end else if (want_idle) begin
               pwr_nxt = SFS_PWR_STANDBY;
            end
         end
         SFS_PWR_BUSY_HOLD: begin
            if (want_active) begin
               pwr_nxt = SFS_PWR_ACTIVE;
            end else if (want_idle) begin
               pwr_nxt = SFS_PWR_STANDBY;
            end
         end
         default: begin
            pwr_nxt = SFS_PWR_STANDBY;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pwr_r <= SFS_PWR_STANDBY;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   // Status outputs.
   assign cmd_start   = start_r;
   assign cmd_end     = end_r;
   assign byte_valid  = bvalid_r;
   assign byte_data   = bdata_r;
   assign byte_index  = bidx_r;
   assign selected    = in_cmd_r;
   assign armed       = armed_r;
   assign pwr_active  = (pwr_r != SFS_PWR_STANDBY);
   assign pwr_standby = (pwr_r == SFS_PWR_STANDBY);

   // Checks.
   a_standby_idle: assert property (@(posedge mclk) disable iff (!nrst)
      (cs_sync_n && !op_busy) |=> pwr_standby)
      else $error("left standby while deselected and idle");

   a_select_active: assert property (@(posedge mclk) disable iff (!nrst)
      !cs_sync_n |=> pwr_active)
      else $error("selected but not active");

   a_no_early_byte: assert property (@(posedge mclk) disable iff (!nrst)
      !armed_r |=> !bvalid_r)
      else $error("byte accepted before first select fall");

   sequence s_fall;
      cs_prev_n_r && !cs_sync_n;
   endsequence

   sequence s_rise;
      !cs_prev_n_r && cs_sync_n;
   endsequence

   sequence s_busy_rise;
      s_rise ##0 op_busy;
   endsequence

   sequence s_busy_done;
      (pwr_r == SFS_PWR_BUSY_HOLD) && cs_sync_n && !op_busy;
   endsequence

   a_start_pulse: assert property (@(posedge mclk) disable iff (!nrst)
      s_fall |=> start_r ##1 !start_r)
      else $error("start pulse missing or long");

   a_end_pulse: assert property (@(posedge mclk) disable iff (!nrst)
      (!cs_prev_n_r && cs_sync_n && in_cmd_r) |=> end_r && !in_cmd_r)
      else $error("end pulse missing");

   a_busy_hold: assert property (@(posedge mclk) disable iff (!nrst)
      (op_busy && pwr_active) |=> pwr_active)
      else $error("standby entered during busy operation");

   a_float_desel: assert property (@(posedge mclk) disable iff (!nrst)
      cs_n |-> !so_oe)
      else $error("output driven while deselected");

   a_byte_framed: assert property (@(posedge mclk) disable iff (!nrst)
      bvalid_r |-> $past(in_cmd_r))
      else $error("byte outside a command frame");

   // Pin-level, framing and byte checks; the windows allow for where the select edge lands
   // against the system clock before the synchroniser sees it.
   a_drive_sel: assert property (@(posedge mclk) disable iff (!nrst)
      !cs_n |-> so_oe)
      else $error("output floating while selected");

   a_start_sel: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(start_r) |-> !cs_sync_n)
      else $error("start pulse while deselected");

   a_pin_start: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(cs_n) |-> ##[2:4] start_r)
      else $error("select fall not framed as a start");

   a_pin_end: assert property (@(posedge mclk) disable iff (!nrst)
      ($rose(cs_n) && in_cmd_r) |-> ##[2:4] end_r)
      else $error("select rise not framed as an end");

   a_end_desel: assert property (@(posedge mclk) disable iff (!nrst)
      end_r |-> !in_cmd_r)
      else $error("frame still open at end pulse");

   a_armed_sticky: assert property (@(posedge mclk) disable iff (!nrst)
      armed_r |=> armed_r)
      else $error("armed flag dropped without reset");

   a_start_arms: assert property (@(posedge mclk) disable iff (!nrst)
      start_r |-> (armed_r && in_cmd_r))
      else $error("start without arming and framing");

   a_byte_armed: assert property (@(posedge mclk) disable iff (!nrst)
      bvalid_r |-> armed_r)
      else $error("byte while unarmed");

   a_byte_single: assert property (@(posedge mclk) disable iff (!nrst)
      bvalid_r |=> !bvalid_r)
      else $error("byte pulse longer than one cycle");

   // Power-state checks.
   a_hold_enter: assert property (@(posedge mclk) disable iff (!nrst)
      s_busy_rise |=> (pwr_r == SFS_PWR_BUSY_HOLD))
      else $error("busy deselect did not hold power");

   a_hold_release: assert property (@(posedge mclk) disable iff (!nrst)
      s_busy_done |=> pwr_standby)
      else $error("hold not released after operation");

   a_pwr_legal: assert property (@(posedge mclk) disable iff (!nrst)
      pwr_r inside {SFS_PWR_STANDBY, SFS_PWR_ACTIVE, SFS_PWR_BUSY_HOLD})
      else $error("illegal power state");

   a_sel_active: assert property (@(posedge mclk) disable iff (!nrst)
      in_cmd_r |-> pwr_active)
      else $error("inside a frame but not active");

endmodule : sfs_select_power

/* File: dv/sfs_host_model.sv */
`timescale 1ns/10ps
// Host controller: owns select, serial clock and serial data in, mode 0 style.
module sfs_host_model;
   logic sck;
   logic cs_n;
   logic si;
   // Clock parks low and select parks high between frames.
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // A falling select opens every frame.
   task automatic select();
      #80 cs_n = 1'b0;
      #80;
   endtask : select
   // Data changes while the clock is low so the rising edge samples it.
   task automatic send_bit(input logic b);
      si = b;
      #80 sck = 1'b1;
      #80 sck = 1'b0;
   endtask : send_bit
   // Bytes go out most significant bit first.
   task automatic send_byte(input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         send_bit(d[i]);
      end
   endtask : send_byte
   // A rising select closes the frame; the released line no longer holds its value.
   task automatic deselect();
      #80 cs_n = 1'b1;
      si = ~si;
      #80;
   endtask : deselect
endmodule : sfs_host_model

/* File: dv/tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
   import sfs_pkg::*;
   logic       mclk = 1'b0;
   logic       nrst = 1'b0;
   logic       op_busy = 1'b0;
   logic       tx_bit = 1'b0;
   logic       so_o, so_oe, cmd_start, cmd_end, byte_valid, selected, armed;
   logic       pwr_active, pwr_standby;
   logic [7:0] byte_data, byte_index;
   int         num_errors = 0, n_compared = 0, cycles = 0;
   int         n_st = 0, n_end = 0, n_byte = 0;
   sfs_host_model host ();
   sfs_select_power DUT (.mclk(mclk), .nrst(nrst), .sck(host.sck), .cs_n(host.cs_n),
      .si(host.si), .so_o(so_o), .so_oe(so_oe), .op_busy(op_busy), .tx_bit(tx_bit),
      .cmd_start(cmd_start), .cmd_end(cmd_end), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_index(byte_index), .selected(selected), .armed(armed),
      .pwr_active(pwr_active), .pwr_standby(pwr_standby));
   // System clock at 100 MHz.
   always #5 mclk = ~mclk;
   // Pulse counters and the hang limit.
   always @(posedge mclk) begin
      n_st += (cmd_start === 1'b1);
      n_end += (cmd_end === 1'b1);
      n_byte += (byte_valid === 1'b1);
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic w(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : w
   // Clocking while deselected must leave no byte and keep the device unarmed.
   task automatic t_idle();
      `CHK(armed, 1'b0)
      `CHK(pwr_standby, 1'b1)
      `CHK(so_oe, 1'b0)
      for (int i = 0; i < 8; i++) host.send_bit(1'b1);
      w(8);
      `CHK(n_byte, 0)
      `CHK(armed, 1'b0)
      $display("test idle done");
   endtask : t_idle
   // Full frame of two bytes with the output bit driven high.
   task automatic t_frame();
      tx_bit = 1'b1;
      host.select();
      w(8);
      `CHK(n_st, 1)
      `CHK(selected, 1'b1)
      `CHK(pwr_active, 1'b1)
      `CHK(so_oe, 1'b1)
      host.send_byte(8'hA5);
      w(8);
      `CHK(byte_data, 8'hA5)
      `CHK(byte_index, 8'h00)
      `CHK(so_o, 1'b1)
      host.send_byte(8'h3C);
      w(8);
      `CHK(byte_index, 8'h01)
      `CHK(n_byte, 2)
      `CHK(byte_data, 8'h3C)
      `CHK(armed, 1'b1)
      host.deselect();
      w(8);
      `CHK(n_end, 1)
      `CHK(selected, 1'b0)
      `CHK(pwr_standby, 1'b1)
      `CHK(so_oe, 1'b0)
      $display("test frame done");
   endtask : t_frame
   // A partial byte is dropped and the next frame starts at the opcode.
   task automatic t_partial();
      tx_bit = 1'b0;
      host.select();
      for (int i = 0; i < 3; i++) host.send_bit(1'b1);
      host.deselect();
      host.select();
      host.send_byte(8'h5A);
      w(8);
      `CHK(byte_data, 8'h5A)
      `CHK(byte_index, 8'h00)
      `CHK(n_byte, 3)
      `CHK(n_st, 3)
      `CHK(so_o, 1'b0)
      host.deselect();
      $display("test partial done");
   endtask : t_partial
   // A running internal operation holds the device out of standby.
   task automatic t_busy();
      op_busy = 1'b1;
      host.select();
      host.deselect();
      w(20);
      `CHK(pwr_active, 1'b1)
      `CHK(pwr_standby, 1'b0)
      `CHK(n_end, 4)
      `CHK(selected, 1'b0)
      op_busy = 1'b0;
      w(8);
      `CHK(pwr_standby, 1'b1)
      $display("test busy done");
   endtask : t_busy
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   // Reset for three cycles, then the scenarios in turn.
   initial begin
      repeat (3) @(negedge mclk);
      nrst = 1'b1;
      w(2);
      t_idle();
      t_frame();
      t_partial();
      t_busy();
      complete_run();
   end
endmodule : tb
